/* File: core/ofel_defines.svh */
// Summary of operation
// - Debounce count register, eight bits, resets zero.
// - Count step time follows data rate, mode.
// - Back/front trip field always reads 01.
// - Z-lockout angle field always reads 100.
// - Trip threshold field always reads 1_0000.
// - Trip margin field always reads 100.
// - Switch portrait at 59, landscape at 31.
// - Combine select picks freefall or motion.
// - All axis enables zero disables detector.
// - Latch enable and combine select: four modes.
// - Unlatched freefall: flag sets after debounce completes.
// - Clear mode 0, unlatched: flag clears after count-down.
// - Clear mode 1: clears at once, re-debounces.
// - Unlatched: source read leaves flag unchanged.
// - Unlatched: axis flags follow raw status.
// - Latched: flag sets at count, holds until read.
// - Latched: read clears flag and counter.
// - Latched: axis flags freeze while flag set.
// - Clear mode bit: 0 decrements, 1 clears; resets 1.
// - Wake/sleep change resets orientation debounce counter.
// - Freefall when enabled magnitudes at/below threshold.
// - Axis flags read zero when axis disabled.
`ifndef OFEL_DEFINES_SVH
`define OFEL_DEFINES_SVH
`define OFEL_ADDR_ORIENT_COUNT 8'h12
`define OFEL_ADDR_BF_Z_LOCKOUT_ANGLE_FIELD 8'h13
`define OFEL_ADDR_THS_MARGIN 8'h14
`define OFEL_ADDR_FM_CFG 8'h15
`define OFEL_ADDR_FM_SRC 8'h16
`define OFEL_ADDR_FM_THS 8'h17
`define OFEL_ADDR_FM_DELAY 8'h18
`define OFEL_ADDR_ORIENT_CFG 8'h11
`define OFEL_ADDR_TIMING 8'h19
`define OFEL_ORIENT_COUNT_RST 8'h00
`define OFEL_BACK_FRONT_TRIP 2'h1
`define OFEL_Z_LOCKOUT_ANGLE 3'h4
`define OFEL_TRIP_THRESHOLD 5'h10
`define OFEL_TRIP_MARGIN 3'h4
`define OFEL_TRIP_TO_PORTRAIT_DEG 8'h3b
`define OFEL_TRIP_TO_LANDSCAPE_DEG 8'h1f
`define OFEL_ORIENT_CFG_RST 8'h80
`define OFEL_CFG_LATCH_BIT 7
`define OFEL_CFG_COMBINE_BIT 6
`define OFEL_CFG_ZEN_BIT 5
`define OFEL_CFG_YEN_BIT 4
`define OFEL_CFG_XEN_BIT 3
`define OFEL_CLEAR_MODE_BIT 7
`define OFEL_SRC_ACTIVE_BIT 7
`define OFEL_CLK_HZ 40000000
`define OFEL_STEP_MIN_US 1250
`define OFEL_STEP_CYCLES ((`OFEL_CLK_HZ / 1000) * `OFEL_STEP_MIN_US / 1000)
`endif

/* File: core/ofel_pkg.sv */
package ofel_pkg;
	// Per-axis sample: magnitude and sign
	typedef struct packed {
		logic negative;
		logic [6:0] magnitude;
	} ofel_axis_type;
	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ofel_bus_type;
	// Step rate: data rate index and oversampling mode
	typedef enum logic [1:0] {
		OFEL_OS_NORMAL,
		OFEL_OS_LOW_NOISE,
		OFEL_OS_FINE,
		OFEL_OS_LOW_POWER
	} ofel_os_type;
	typedef enum logic [1:0] {
		OFEL_MODE_FALL_LIVE,
		OFEL_MODE_FALL_LATCH,
		OFEL_MODE_MOTION_LIVE,
		OFEL_MODE_MOTION_LATCH
	} ofel_mode_type;
endpackage

/* File: core/ofel_event_logic.sv */
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "ofel_defines.svh"
module ofel_event_logic
	import ofel_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire ofel_bus_type bus,
	output logic [7:0] rdata,
	input wire logic [2:0] data_rate_sel,
	input wire ofel_os_type os_mode,
	input wire logic sleep_mode,
	input wire logic sample_valid,
	input wire ofel_axis_type [2:0] axis,
	input wire logic [7:0] tilt_angle,
	output logic event_active_flag,
	output logic portrait_orientation
);
	// Registers
	logic [7:0] orientation_debounce_register;
	logic [7:0] orient_cfg;
	logic [7:0] fm_cfg;
	logic [6:0] fall_motion_threshold;
	logic [7:0] fall_motion_debounce_delay;
	logic [7:0] fm_cnt;
	logic [7:0] orient_cnt;
	logic [5:0] axis_flags;
	logic [15:0] step_timer;
	logic [6:0] tick_div;
	logic sleep_q;
	logic blocked;

	// Decodes
	wire wr_orient_count = bus.wr && bus.addr == `OFEL_ADDR_ORIENT_COUNT;
	wire wr_orient_cfg = bus.wr && bus.addr == `OFEL_ADDR_ORIENT_CFG;
	wire wr_fm_cfg = bus.wr && bus.addr == `OFEL_ADDR_FM_CFG;
	wire wr_fm_ths = bus.wr && bus.addr == `OFEL_ADDR_FM_THS;
	wire wr_fm_delay = bus.wr && bus.addr == `OFEL_ADDR_FM_DELAY;
	wire rd_src = bus.rd && bus.addr == `OFEL_ADDR_FM_SRC;
	wire debounce_clear_mode = orient_cfg[`OFEL_CLEAR_MODE_BIT];
	wire event_latch_enable = fm_cfg[`OFEL_CFG_LATCH_BIT];
	wire and_or_combine_select = fm_cfg[`OFEL_CFG_COMBINE_BIT];
	wire [2:0] axis_en = {fm_cfg[`OFEL_CFG_ZEN_BIT], fm_cfg[`OFEL_CFG_YEN_BIT],
		fm_cfg[`OFEL_CFG_XEN_BIT]};
	wire ofel_mode_type mode = ofel_mode_type'({and_or_combine_select,
		event_latch_enable});

	// Step time: base 1.25 ms multiplied by a power of two
	// 800 Hz gives x1 in every mode, fine mode stops at x2, others per table
	logic [3:0] step_shift;
	always_comb begin
		unique case (os_mode)
			OFEL_OS_FINE: step_shift = (data_rate_sel == 3'h0) ? 4'h0 : 4'h1;
			OFEL_OS_NORMAL: step_shift = (data_rate_sel > 3'h4) ? 4'h4 :
				{1'b0, data_rate_sel};
			OFEL_OS_LOW_NOISE: step_shift = (data_rate_sel > 3'h4) ? 4'h6 :
				{1'b0, data_rate_sel};
			OFEL_OS_LOW_POWER: step_shift = (data_rate_sel > 3'h5) ? 4'h7 :
				(data_rate_sel == 3'h5) ? 4'h6 : {1'b0, data_rate_sel};
		endcase
	end

	// Base 1.25 ms timer and power-of-two divider
	wire base_tick = step_timer == 16'(`OFEL_STEP_CYCLES - 1);
	// Divider spans the full x128 step of the slowest low-power rate
	wire [6:0] next_tick_div = tick_div + 7'h01;
	wire [6:0] tick_mask = (7'h01 << step_shift[2:0]) - 7'h01;
	wire step_tick = base_tick && (tick_div & tick_mask) == 7'h00;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			step_timer <= 16'h0000;
			tick_div <= 7'h00;
		end else begin
			step_timer <= base_tick ? 16'h0000 : step_timer + 16'h0001;
			tick_div <= base_tick ? next_tick_div : tick_div;
		end
	end

	// Per-axis raw detection
	logic [2:0] below, above;
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_axis
			assign below[i] = axis[i].magnitude <= fall_motion_threshold;
			assign above[i] = axis[i].magnitude > fall_motion_threshold;
		end
	endgenerate
	wire any_en = |axis_en;
	wire fall_cond = any_en && ((below | ~axis_en) == 3'h7);
	wire motion_cond = any_en && |(above & axis_en);
	wire cond = and_or_combine_select ? motion_cond : fall_cond;
	logic [5:0] raw_flags;
	always_comb begin
		raw_flags = 6'h00;
		for (int k = 0; k < 3; k++) begin
			raw_flags[2 * k + 1] = axis_en[k] &&
				(and_or_combine_select ? above[k] : below[k]);
			raw_flags[2 * k] = raw_flags[2 * k + 1] && axis[k].negative;
		end
	end

	// Fall/motion debounce counter and event flag
	wire counted = fm_cnt >= fall_motion_debounce_delay;
	logic [7:0] next_fm_cnt;
	logic next_active;
	logic next_blocked;
	always_comb begin
		next_fm_cnt = fm_cnt;
		next_active = event_active_flag;
		next_blocked = blocked;
		if (!any_en) begin
			next_fm_cnt = 8'h00;
			next_active = 1'b0;
		end else if (event_latch_enable) begin
			if (rd_src) begin
				next_fm_cnt = 8'h00;
				next_active = 1'b0;
			end else if (sample_valid && !event_active_flag) begin
				if (cond) begin
					next_fm_cnt = counted ? fm_cnt : fm_cnt + 8'h01;
					next_active = counted;
				end else if (debounce_clear_mode) begin
					next_fm_cnt = 8'h00;
				end else if (fm_cnt != 8'h00) begin
					next_fm_cnt = fm_cnt - 8'h01;
				end
			end
		end else if (sample_valid) begin
			// Live modes: reading the source changes nothing
			if (cond) begin
				next_fm_cnt = counted ? fm_cnt : fm_cnt + 8'h01;
				next_active = counted && !blocked;
				next_blocked = 1'b0;
			end else if (debounce_clear_mode) begin
				next_fm_cnt = 8'h00;
				next_active = 1'b0;
			end else begin
				next_fm_cnt = (fm_cnt != 8'h00) ? fm_cnt - 8'h01 : 8'h00;
				next_active = event_active_flag && fm_cnt > 8'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fm_cnt <= 8'h00;
			event_active_flag <= 1'b0;
			blocked <= 1'b0;
		end else begin
			fm_cnt <= next_fm_cnt;
			event_active_flag <= next_active;
			blocked <= next_blocked;
		end
	end

	// Axis flags: live, or frozen while latched event stands
	wire latched_mode = mode == OFEL_MODE_FALL_LATCH ||
		mode == OFEL_MODE_MOTION_LATCH;
	wire freeze = latched_mode && event_active_flag && !rd_src;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			axis_flags <= 6'h00;
		else if (!freeze)
			axis_flags <= raw_flags;
	end

	// Orientation debounce with fixed trip angles
	wire want_portrait = portrait_orientation ?
		tilt_angle > `OFEL_TRIP_TO_LANDSCAPE_DEG :
		tilt_angle >= `OFEL_TRIP_TO_PORTRAIT_DEG;
	wire orient_change = want_portrait != portrait_orientation;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			orient_cnt <= 8'h00;
			portrait_orientation <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			sleep_q <= sleep_mode;
			if (sleep_q != sleep_mode)
				orient_cnt <= 8'h00;
			else if (!orient_change)
				orient_cnt <= 8'h00;
			else if (step_tick) begin
				if (orient_cnt >= orientation_debounce_register) begin
					portrait_orientation <= want_portrait;
					orient_cnt <= 8'h00;
				end else
					orient_cnt <= orient_cnt + 8'h01;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			orientation_debounce_register <= `OFEL_ORIENT_COUNT_RST;
			orient_cfg <= `OFEL_ORIENT_CFG_RST;
			fm_cfg <= 8'h00;
			fall_motion_threshold <= 7'h00;
			fall_motion_debounce_delay <= 8'h00;
		end else begin
			if (wr_orient_count)
				orientation_debounce_register <= bus.wdata;
			if (wr_orient_cfg)
				orient_cfg <= {bus.wdata[7:6], 6'h00};
			if (wr_fm_cfg)
				fm_cfg <= {bus.wdata[7:3], 3'h0};
			if (wr_fm_ths)
				fall_motion_threshold <= bus.wdata[6:0];
			if (wr_fm_delay)
				fall_motion_debounce_delay <= bus.wdata;
		end
	end

	// Read mux; unmapped addresses read zero
	logic [7:0] rd_mux;
	always_comb begin
		unique case (bus.addr)
			`OFEL_ADDR_ORIENT_COUNT: rd_mux = orientation_debounce_register;
			`OFEL_ADDR_BF_Z_LOCKOUT_ANGLE_FIELD: rd_mux = {`OFEL_BACK_FRONT_TRIP, 3'h0,
				`OFEL_Z_LOCKOUT_ANGLE};
			`OFEL_ADDR_THS_MARGIN: rd_mux = {`OFEL_TRIP_THRESHOLD,
				`OFEL_TRIP_MARGIN};
			`OFEL_ADDR_ORIENT_CFG: rd_mux = orient_cfg;
			`OFEL_ADDR_FM_CFG: rd_mux = fm_cfg;
			`OFEL_ADDR_FM_SRC: rd_mux = {event_active_flag, 1'b0,
				axis_flags & {{2{axis_en[2]}}, {2{axis_en[1]}},
				{2{axis_en[0]}}}};
			`OFEL_ADDR_FM_THS: rd_mux = {1'b0, fall_motion_threshold};
			`OFEL_ADDR_FM_DELAY: rd_mux = fall_motion_debounce_delay;
			default: rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rdata <= 8'h00;
		else if (bus.rd)
			rdata <= rd_mux;
		else
			rdata <= 8'h00;
	end
endmodule

/* File: sim/ofel_event_logic_props.sv */
`timescale 1ns/1ps
module ofel_event_logic_props
	import ofel_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire ofel_bus_type bus,
	input wire logic [7:0] rdata,
	input wire logic sample_valid,
	input wire logic event_active_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Read data only in the cycle after a read
	rd_idle_a: assert property (!bus.rd |=> rdata == 8'h00)
		else $error("read data not zero without read");
	bf_fixed_a: assert property (bus.rd && bus.addr == 8'h13 |=>
		rdata == 8'h44) else $error("angle register wrong");
	ths_fixed_a: assert property (bus.rd && bus.addr == 8'h14 |=>
		rdata == 8'h84) else $error("threshold register wrong");
	count_rw_a: assert property (bus.wr && bus.addr == 8'h12 ##1 !bus.wr
		##1 bus.rd && bus.addr == 8'h12 |=> rdata == $past(bus.wdata, 3))
		else $error("count register lost write");
	src_flag_a: assert property (bus.rd && bus.addr == 8'h16 |=>
		rdata[7] == $past(event_active_flag) && !rdata[6])
		else $error("source register flag wrong");
	flag_rise_a: assert property ($rose(event_active_flag) |->
		$past(sample_valid)) else $error("flag rose without sample");
	off_clear_a: assert property (bus.wr && bus.addr == 8'h15 &&
		bus.wdata[5:3] == 3'h0 |=> ##1 !event_active_flag)
		else $error("flag set with axes disabled");
	unmap_zero_a: assert property (bus.rd && bus.addr < 8'h11 |=>
		rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind ofel_event_logic ofel_event_logic_props u_props(.clk(clk), .nrst(nrst),
	.bus(bus), .rdata(rdata), .sample_valid(sample_valid),
	.event_active_flag(event_active_flag));

/* File: sim/ofel_event_logic_tb.sv */
`timescale 1ns/1ps
module ofel_event_logic_tb;
	import ofel_pkg::*;
	logic clk = 0, nrst = 0, sleep_mode = 0, sample_valid = 0;
	logic [7:0] rdata, tilt_angle = 0, v;
	logic [2:0] data_rate_sel = 0;
	logic event_active_flag, portrait_orientation;
	ofel_bus_type bus = '0;
	ofel_os_type os_mode = OFEL_OS_NORMAL;
	ofel_axis_type [2:0] axis = '0;
	int n_errors = 0, total_checks = 0, d = 3;
	always #12.5 clk = ~clk;
	ofel_event_logic DUT(.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
		.data_rate_sel(data_rate_sel), .os_mode(os_mode),
		.sleep_mode(sleep_mode), .sample_valid(sample_valid), .axis(axis),
		.tilt_angle(tilt_angle), .event_active_flag(event_active_flag),
		.portrait_orientation(portrait_orientation));
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk) bus <= {a, x, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk) bus <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
		#1 v = rdata;
	endtask
	// One output sample, inside or outside the fall window
	task smp(input bit q);
		@(posedge clk);
		for (int i = 0; i < 3; i++)
			axis[i] <= {1'($urandom), q ? 7'($urandom % 17) : 7'h40};
		sample_valid <= 1'b1;
		tilt_angle <= 8'($urandom);
		@(posedge clk) sample_valid <= 1'b0;
	endtask
	task fl(input logic e);
		#1 chk("event flag", {7'h0, event_active_flag}, {7'h0, e});
	endtask
	task conclude;
		$display("Checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#2400000;
		n_errors++;
		conclude();
	end
	initial begin
		void'($urandom(32'hb0f974c3));
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd(8'h12); chk("count reset", v, 8'h00);
		rd(8'h11); chk("clear mode reset", v, 8'h80);
		wr(8'h13, 8'hff); wr(8'h14, 8'h00);
		rd(8'h13); chk("angles", v, 8'h44);
		rd(8'h14); chk("threshold", v, 8'h84);
		rd(8'h05); chk("unmapped", v, 8'h00);
		data_rate_sel <= 3'($urandom);
		os_mode <= OFEL_OS_LOW_POWER;
		wr(8'h12, 8'h5a); rd(8'h12); chk("count rw", v, 8'h5a);
		sleep_mode <= 1'b1;
		wr(8'h17, 8'h10); wr(8'h18, 8'(d));
		$display("Registers done");
		wr(8'h15, 8'hb8);
		repeat (d - 1) smp(1);
		fl(0);
		repeat (2) smp(1);
		fl(1);
		repeat (2) smp(0);
		fl(1);
		rd(8'h16); chk("latched source", v & 8'h80, 8'h80);
		fl(0);
		repeat (d - 1) smp(1);
		fl(0);
		$display("Latched fall done");
		sleep_mode <= 1'b0;
		wr(8'h15, 8'h00); fl(0);
		wr(8'h15, 8'h38);
		repeat (d + 1) smp(1);
		fl(1);
		rd(8'h16); fl(1);
		smp(0); fl(0);
		repeat (d - 1) smp(1);
		fl(0);
		$display("Live fall done");
		wr(8'h11, 8'h00); wr(8'h15, 8'h00); wr(8'h15, 8'h38);
		repeat (d + 1) smp(1);
		@(posedge clk) axis <= '1;
		@(posedge clk) fl(1);
		repeat (2) smp(0);
		fl(1);
		repeat (d + 1) smp(0);
		fl(0);
		wr(8'h15, 8'h08);
		smp(0);
		rd(8'h16); chk("disabled axes", v & 8'h3c, 8'h00);
		$display("Decrement and axis done");
		// Orientation: boundary tilt switches at the first step tick
		@(posedge clk) begin
			os_mode <= OFEL_OS_NORMAL;
			data_rate_sel <= 3'h0;
			tilt_angle <= 8'd59;
		end
		wr(8'h12, 8'h00);
		#1 chk("landscape start", {7'h0, portrait_orientation}, 8'h00);
		repeat (50100) @(posedge clk);
		#1 chk("portrait trip", {7'h0, portrait_orientation}, 8'h01);
		$display("Orientation done");
		conclude();
	end
endmodule
